// *** design/alc_level_comparator.sv ***
// Level comparator for one selectable measured quantity, with registers,
// routing outputs and an interrupt. Assumes synchronous inputs on mclk
// and a one-cycle sampleEn strobe from the system sample timer.
`timescale 1ns/10ps
`include "alc_map.svh"
module alc_level_comparator
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sampleEn,
  input wire alc_pkg::alc_src_t srcVals,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  output logic compOut,
  output logic [7:0] vlinkOut,
  output logic [1:0] digOut,
  output logic [2:0] relayOut,
  output logic irq
);
  import alc_pkg::*;

  // ***************************************************
  // Registers
  // ***************************************************
  alc_sel_t selFf;
  alc_type_e typeFf;
  alc_pol_e polFf;
  alc_val_t hiFf;
  alc_val_t loFf;
  alc_val_t maxSpdFf;
  alc_val_t maxTrqFf;
  alc_val_t motPnFf;
  alc_val_t motInFf;
  alc_val_t prcMinFf;
  alc_val_t prcMaxFf;
  logic [12:0] routeFf;
  logic [1:0] irqStatFf;
  logic [1:0] irqMaskFf;
  logic outFf;
  logic [31:0] rdFf;

  logic wrCtrl;
  logic clrReq;
  logic selValid;
  alc_val_t rawSel;
  alc_val_t selVal;
  alc_val_t uniMin;
  alc_val_t uniMax;
  alc_val_t minLim;
  alc_val_t maxLim;
  alc_val_t hiEff;
  alc_val_t loEff;
  logic hiClip;
  logic loClip;
  logic latchMode;
  logic inWin;
  logic nxt_out;
  logic [1:0] events;
  logic [1:0] nxt_irqStat;
  logic [31:0] nxt_rd;

  assign wrCtrl = regWr && (regAddr == `ALC_OFF_CTRL);
  assign clrReq = wrCtrl && regWdata[`ALC_CTRL_CLR];

  // ***************************************************
  // Configuration registers
  // ***************************************************
  // Selector, type and polarity codes
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      selFf <= `ALC_RST_SEL;
      typeFf <= ALC_HYST;
      polFf <= ALC_UNIPOLAR;
    end
    else if (wrCtrl)
    begin
      selFf <= regWdata[4:0];
      typeFf <= alc_type_e'(regWdata[`ALC_CTRL_TYPE]);
      polFf <= alc_pol_e'(regWdata[`ALC_CTRL_POL]);
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hiFf <= `ALC_RST_HI;
      loFf <= `ALC_RST_LO;
    end
    else if (regWr)
    begin
      if (regAddr == `ALC_OFF_HI)
        hiFf <= regWdata;
      if (regAddr == `ALC_OFF_LO)
        loFf <= regWdata;
    end
  end

  // Motor ratings and process span scale the variable limits
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      maxSpdFf <= `ALC_RST_MAXSPD;
      maxTrqFf <= `ALC_RST_MAXTRQ;
      motPnFf <= `ALC_RST_MOTPN;
      motInFf <= `ALC_RST_MOTIN;
      prcMinFf <= `ALC_RST_PRCMIN;
      prcMaxFf <= `ALC_RST_PRCMAX;
    end
    else if (regWr)
    begin
      case (regAddr)
        `ALC_OFF_MAXSPD: maxSpdFf <= regWdata;
        `ALC_OFF_MAXTRQ: maxTrqFf <= regWdata;
        `ALC_OFF_MOTPN: motPnFf <= regWdata;
        `ALC_OFF_MOTIN: motInFf <= regWdata;
        `ALC_OFF_PRCMIN: prcMinFf <= regWdata;
        `ALC_OFF_PRCMAX: prcMaxFf <= regWdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      routeFf <= 13'h0;
      irqMaskFf <= 2'h0;
    end
    else if (regWr)
    begin
      if (regAddr == `ALC_OFF_ROUTE)
        routeFf <= regWdata[12:0];
      if (regAddr == `ALC_OFF_IRQM)
        irqMaskFf <= regWdata[1:0];
    end
  end

  // ***************************************************
  // Source selection and polarity
  // ***************************************************
  // Codes above 26 select nothing
  assign selValid = (selFf <= `ALC_SEL_LAST);
  assign rawSel = selValid ? srcVals[selFf] : 32'sh00000000;

  always_comb
  begin
    selVal = rawSel;
    if (polFf == ALC_UNIPOLAR && rawSel < 32'sh00000000)
      selVal = 32'sh00000000 - rawSel;
  end

  // ***************************************************
  // Threshold limits
  // ***************************************************
  // Per-source limit table
  always_comb
  begin
    uniMin = 32'sh00000000;
    uniMax = 32'sh00000000;
    case (selFf)
      5'h00, 5'h14, 5'h15:
      begin
        uniMin = prcMinFf;
        uniMax = prcMaxFf;
      end
      5'h01: uniMax = maxSpdFf;
      5'h02: uniMax = maxTrqFf;
      5'h03, 5'h04: uniMax = alc_val_t'({motPnFf[29:0], 2'b00});
      5'h05: uniMax = alc_val_t'({motInFf[29:0], 2'b00});
      5'h06: uniMax = `ALC_LIM_VOLT;
      5'h07: uniMax = `ALC_LIM_FREQ;
      5'h08: uniMax = `ALC_LIM_DCV;
      5'h09: uniMax = `ALC_LIM_STG;
      5'h0a, 5'h0b, 5'h0c, 5'h16, 5'h17, 5'h18:
      begin
        uniMin = `ALC_LIM_PRB_MIN;
        uniMax = `ALC_LIM_PRB_MAX;
      end
      5'h0d: uniMax = `ALC_LIM_ENERGY;
      5'h0e, 5'h0f: uniMax = `ALC_LIM_TIME;
      5'h10, 5'h11, 5'h12, 5'h13, 5'h19, 5'h1a: uniMax = `ALC_LIM_PCT;
      default: uniMax = 32'sh00000000;
    endcase
  end

  assign minLim = (polFf == ALC_BIPOLAR) ? 32'sh00000000 - uniMax : uniMin;
  assign maxLim = uniMax;

  // Thresholds clamped to the live range
  // Clamped on use so a later source change never leaves stale limits
  alc_clamp u_clampHi
  (
    .rawVal(hiFf),
    .minVal(minLim),
    .maxVal(maxLim),
    .limVal(hiEff),
    .clipped(hiClip)
  );

  alc_clamp u_clampLo
  (
    .rawVal(loFf),
    .minVal(minLim),
    .maxVal(maxLim),
    .limVal(loEff),
    .clipped(loClip)
  );

  // ***************************************************
  // Comparator
  // ***************************************************
  assign latchMode = (typeFf == ALC_HYST) && (loEff > hiEff);
  assign inWin = (selVal >= loEff) && (selVal <= hiEff);

  always_comb
  begin
    nxt_out = outFf;
    if (typeFf == ALC_WIN)
      nxt_out = inWin;
    else if (selVal >= hiEff)
      nxt_out = 1'b1;
    else if (latchMode)
      nxt_out = outFf;
    else if (selVal < loEff)
      nxt_out = 1'b0;
  end

  // Update on sample strobe, clear forces low
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      outFf <= 1'b0;
    else if (clrReq)
      outFf <= 1'b0;
    else if (sampleEn && selValid)
      outFf <= nxt_out;
  end

  // ***************************************************
  // Routing outputs
  // ***************************************************
  // Output steered to enabled consumers
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      compOut <= 1'b0;
      vlinkOut <= 8'h00;
      digOut <= 2'h0;
      relayOut <= 3'h0;
    end
    else
    begin
      compOut <= outFf;
      vlinkOut <= routeFf[7:0] & {8{outFf}};
      digOut <= routeFf[9:8] & {2{outFf}};
      relayOut <= routeFf[12:10] & {3{outFf}};
    end
  end

  // ***************************************************
  // Interrupts
  // ***************************************************
  // Rising and falling output edges; a new edge beats the W1C clear
  assign events = {~outFf & ~clrReq & sampleEn & selValid & nxt_out,
                   outFf & (clrReq | (sampleEn & selValid & ~nxt_out))};
  always_comb
  begin
    nxt_irqStat = irqStatFf;
    if (regWr && regAddr == `ALC_OFF_IRQS)
      nxt_irqStat = irqStatFf & ~regWdata[1:0];
    nxt_irqStat = nxt_irqStat | {events[0], events[1]};
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irqStatFf <= 2'h0;
      irq <= 1'b0;
    end
    else
    begin
      irqStatFf <= nxt_irqStat;
      irq <= |(nxt_irqStat & irqMaskFf);
    end
  end

  // ***************************************************
  // Read port
  // ***************************************************
  always_comb
  begin
    nxt_rd = 32'h00000000;
    case (regAddr)
      `ALC_OFF_CTRL: nxt_rd = {25'h0, polFf, typeFf, selFf};
      `ALC_OFF_HI: nxt_rd = hiFf;
      `ALC_OFF_LO: nxt_rd = loFf;
      `ALC_OFF_STAT:
        nxt_rd = {27'h0, ~selValid, loClip, hiClip, latchMode, outFf};
      `ALC_OFF_IRQS: nxt_rd = {30'h0, irqStatFf};
      `ALC_OFF_IRQM: nxt_rd = {30'h0, irqMaskFf};
      `ALC_OFF_ROUTE: nxt_rd = {19'h0, routeFf};
      `ALC_OFF_MAXSPD: nxt_rd = maxSpdFf;
      `ALC_OFF_MAXTRQ: nxt_rd = maxTrqFf;
      `ALC_OFF_MOTPN: nxt_rd = motPnFf;
      `ALC_OFF_MOTIN: nxt_rd = motInFf;
      `ALC_OFF_PRCMIN: nxt_rd = prcMinFf;
      `ALC_OFF_PRCMAX: nxt_rd = prcMaxFf;
      `ALC_OFF_SELVAL: nxt_rd = selVal;
      default: nxt_rd = 32'h00000000;
    endcase
  end

  // Data only in the cycle after the strobe; zero otherwise
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rdFf <= 32'h00000000;
    else if (regRd)
      rdFf <= nxt_rd;
    else
      rdFf <= 32'h00000000;
  end
  assign regRdata = rdFf;

  // ***************************************************
  // Assertions
  // ***************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  logic evalHyst;
  assign evalHyst = sampleEn && selValid && !clrReq && typeFf == ALC_HYST;

  sequence s_atUpper;
    evalHyst && selVal >= hiEff;
  endsequence

  sequence s_belowLower;
    evalHyst && !latchMode && selVal < loEff && selVal < hiEff;
  endsequence

  sequence s_inBand;
    evalHyst && !latchMode && selVal >= loEff && selVal < hiEff;
  endsequence

  a_hyst_set: assert property (s_atUpper |=> outFf)
    else $error("upper level did not set output");

  a_hyst_clear: assert property (s_belowLower |=> !outFf)
    else $error("lower level did not clear output");

  a_hyst_hold: assert property (s_inBand |=> $stable(outFf))
    else $error("output moved inside hysteresis band");

  a_latch_hold: assert property
    (latchMode && outFf && !clrReq && !wrCtrl ##1 latchMode && !clrReq
     |=> outFf)
    else $error("latched output dropped");

  a_win_level: assert property
    (sampleEn && selValid && !clrReq && typeFf == ALC_WIN
     |=> outFf == $past(inWin))
    else $error("window output wrong");

  a_idle_hold: assert property
    (!sampleEn && !clrReq |=> $stable(outFf))
    else $error("output changed without sample strobe");

  a_clr_low: assert property (clrReq |=> !outFf ##1 !compOut)
    else $error("clear did not force output low");

  a_hi_range: assert property
    (hiEff >= minLim && hiEff <= maxLim && loEff >= minLim && loEff <= maxLim)
    else $error("threshold outside source range");

  a_bip_min: assert property
    (polFf == ALC_BIPOLAR |-> minLim == 32'sh00000000 - maxLim)
    else $error("bipolar minimum not negative maximum");

  a_uni_abs: assert property
    (polFf == ALC_UNIPOLAR && selValid |-> selVal >= 32'sh00000000)
    else $error("unipolar value negative");

  a_route_link: assert property
    ($stable(routeFf) |-> vlinkOut == (routeFf[7:0] & {8{$past(outFf)}}))
    else $error("virtual link output wrong");
endmodule : alc_level_comparator

// *** design/alc_map.svh ***
// Register map, field positions, reset values and source limits of the
// level comparator. Definitions only; included by the comparator.
`ifndef ALC_MAP_SVH
`define ALC_MAP_SVH

// ***************************************************
// Register offsets (byte addresses)
// ***************************************************
`define ALC_OFF_CTRL 8'h00
`define ALC_OFF_HI 8'h04
`define ALC_OFF_LO 8'h08
`define ALC_OFF_STAT 8'h0c
`define ALC_OFF_IRQS 8'h10
`define ALC_OFF_IRQM 8'h14
`define ALC_OFF_ROUTE 8'h18
`define ALC_OFF_MAXSPD 8'h1c
`define ALC_OFF_MAXTRQ 8'h20
`define ALC_OFF_MOTPN 8'h24
`define ALC_OFF_MOTIN 8'h28
`define ALC_OFF_PRCMIN 8'h2c
`define ALC_OFF_PRCMAX 8'h30
`define ALC_OFF_SELVAL 8'h34

// ***************************************************
// Control fields
// ***************************************************
`define ALC_CTRL_TYPE 5
`define ALC_CTRL_POL 6
`define ALC_CTRL_CLR 7
`define ALC_SEL_LAST 5'h1a

// ***************************************************
// Reset values
// ***************************************************
`define ALC_RST_SEL 5'h01
`define ALC_RST_HI 32'sh0000012c
`define ALC_RST_LO 32'sh000000c8
`define ALC_RST_MAXSPD 32'sh000005dc
`define ALC_RST_MAXTRQ 32'sh00000064
`define ALC_RST_MOTPN 32'sh0000000f
`define ALC_RST_MOTIN 32'sh0000001e
`define ALC_RST_PRCMIN 32'sh00000000
`define ALC_RST_PRCMAX 32'sh00000064

// ***************************************************
// Fixed source limits
// ***************************************************
`define ALC_LIM_VOLT 32'sh000003e8
`define ALC_LIM_FREQ 32'sh00000190
`define ALC_LIM_DCV 32'sh000004e2
`define ALC_LIM_STG 32'sh00000064
`define ALC_LIM_PRB_MIN 32'shffffff9c
`define ALC_LIM_PRB_MAX 32'sh0000012c
`define ALC_LIM_ENERGY 32'sh000f4240
`define ALC_LIM_TIME 32'sh0000ffff
`define ALC_LIM_PCT 32'sh00000064

`endif

// *** design/alc_pkg.sv ***
// Types shared by the level comparator files.
// Assumes scaled signed integers for every measured quantity.
package alc_pkg;
  typedef logic signed [31:0] alc_val_t;
  typedef alc_val_t [26:0] alc_src_t;
  typedef logic [4:0] alc_sel_t;
  typedef enum logic
  {
    ALC_HYST = 1'b0,
    ALC_WIN = 1'b1
  } alc_type_e;
  typedef enum logic
  {
    ALC_UNIPOLAR = 1'b0,
    ALC_BIPOLAR = 1'b1
  } alc_pol_e;
endpackage : alc_pkg

// *** design/alc_clamp.sv ***
// Limits a threshold to the range of the selected source.
// Assumes minVal is not above maxVal.
`timescale 1ns/10ps
module alc_clamp
(
  input wire alc_pkg::alc_val_t rawVal,
  input wire alc_pkg::alc_val_t minVal,
  input wire alc_pkg::alc_val_t maxVal,
  output alc_pkg::alc_val_t limVal,
  output logic clipped
);
  import alc_pkg::*;

  always_comb
  begin
    limVal = rawVal;
    clipped = 1'b0;
    if (rawVal < minVal)
    begin
      limVal = minVal;
      clipped = 1'b1;
    end
    else if (rawVal > maxVal)
    begin
      limVal = maxVal;
      clipped = 1'b1;
    end
  end
endmodule : alc_clamp

// *** verification/alc_testbench.sv ***
// Self-checking bench for the level comparator: registers, modes, routing.
// Assumes alc_pkg and the design files are compiled before this one.
`timescale 1ns/10ps
`include "alc_map.svh"
module testbench;
  import alc_pkg::*;
  logic mclk;
  logic rst_n;
  logic sampleEn;
  alc_src_t srcVals;
  logic [7:0] regAddr;
  logic [31:0] regWdata;
  logic regWr;
  logic regRd;
  logic [31:0] regRdata;
  logic compOut;
  logic [7:0] vlinkOut;
  logic [1:0] digOut;
  logic [2:0] relayOut;
  logic irq;
  int errCount;
  int testsRun;
  int cycles;
  logic [31:0] rdVal;
  logic model;
  logic [4:0] curSel;
  logic curWin;
  logic curPol;
  int curHi;
  int curLo;
  logic [12:0] route;
  logic [7:0] rstOffs [7] = '{`ALC_OFF_CTRL, `ALC_OFF_HI, `ALC_OFF_LO,
    `ALC_OFF_STAT, `ALC_OFF_ROUTE, `ALC_OFF_IRQM, 8'h40};
  logic [31:0] rstVals [7] = '{32'h01, 32'h12c, 32'hc8, 32'h0, 32'h0,
    32'h0, 32'h0};

  alc_level_comparator dut
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .sampleEn(sampleEn),
    .srcVals(srcVals),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWr(regWr),
    .regRd(regRd),
    .regRdata(regRdata),
    .compOut(compOut),
    .vlinkOut(vlinkOut),
    .digOut(digOut),
    .relayOut(relayOut),
    .irq(irq)
  );

  always #50 mclk = ~mclk;

  // ***************************************************
  // Checking and bus tasks
  // ***************************************************
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp,
    input string what);
    testsRun++;
    if (got !== exp)
    begin
      errCount++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk32

  task automatic chk1(input logic got, input logic exp, input string what);
    chk32({31'h0, got}, {31'h0, exp}, what);
  endtask : chk1

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
    rdVal = regRdata;
  endtask : rd

  // Expected output; thresholds are kept inside the source range
  function automatic logic expOut(input int v, input logic prev);
    int a;
    a = (curPol || v >= 0) ? v : -v;
    if (curWin)
      return (a >= curLo && a <= curHi);
    if (a >= curHi)
      return 1'b1;
    if (curLo <= curHi && a < curLo)
      return 1'b0;
    return prev;
  endfunction : expOut

  // Configure and clear, so every test starts from a low output
  task automatic cfg(input int s, input logic w, input logic p,
    input int hi, input int lo);
    curSel = s[4:0];
    curWin = w;
    curPol = p;
    curHi = hi;
    curLo = lo;
    wr(`ALC_OFF_HI, hi);
    wr(`ALC_OFF_LO, lo);
    wr(`ALC_OFF_CTRL, {24'h0, 1'b1, p, w, curSel});
    model = 1'b0;
  endtask : cfg

  task automatic sample(input int v, input logic live);
    @(posedge mclk);
    srcVals[curSel] <= v;
    sampleEn <= 1'b1;
    @(posedge mclk);
    sampleEn <= 1'b0;
    @(posedge mclk);
    #1;
    if (live)
      model = expOut(v, model);
    chk1(compOut, model, "comparator output");
  endtask : sample

  task automatic done(input string name);
    $display("test %s finished, mismatches so far %0d", name, errCount);
  endtask : done

  task automatic results();
    $display("comparisons %0d, mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  // Ceiling well above the roughly 870 cycles the tests need
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errCount++;
      $display("[FAIL] %0t run did not finish", $time);
      results();
    end
  end

  // ***************************************************
  // Test sequence
  // ***************************************************
  initial
  begin
    mclk = 1'b0;
    rst_n = 1'b0;
    sampleEn = 1'b0;
    srcVals = '0;
    regAddr = 8'h0;
    regWdata = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    errCount = 0;
    testsRun = 0;
    cycles = 0;
    model = 1'b0;
    curSel = 5'h01;
    void'($urandom(32'h8d65));
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    wr(8'h40, 32'hffff);
    foreach (rstOffs[i])
    begin
      rd(rstOffs[i]);
      chk32(rdVal, rstVals[i], "reset value");
    end
    done("reset");
    cfg(1, 1'b0, 1'b0, 300, 200);
    sample(250, 1'b1);
    sample(300, 1'b1);
    sample(250, 1'b1);
    sample(200, 1'b1);
    sample(199, 1'b1);
    repeat (40) sample($urandom_range(600), 1'b1);
    done("hysteresis");
    cfg(16, 1'b1, 1'b0, 70, 30);
    sample(30, 1'b1);
    sample(71, 1'b1);
    sample(70, 1'b1);
    sample(29, 1'b1);
    repeat (30) sample($urandom_range(100), 1'b1);
    done("window");
    cfg(10, 1'b0, 1'b0, 50, 20);
    repeat (30) sample($urandom_range(600) - 300, 1'b1);
    sample(-40, 1'b1);
    rd(`ALC_OFF_SELVAL);
    chk32(rdVal, 32'h28, "absolute value");
    cfg(10, 1'b0, 1'b1, 250, -200);
    repeat (30) sample($urandom_range(600) - 300, 1'b1);
    done("polarity");
    for (int k = 0; k < 27; k++)
      srcVals[k] <= 999;
    for (int k = 0; k < 27; k++)
    begin
      cfg(k, 1'b1, 1'b0, 50, 0);
      sample(25, 1'b1);
      sample(999, 1'b1);
    end
    done("sources");
    cfg(1, 1'b0, 1'b0, 200, 400);
    rd(`ALC_OFF_STAT);
    chk32(rdVal, 32'h02, "latch status");
    sample(250, 1'b1);
    sample(0, 1'b1);
    wr(`ALC_OFF_CTRL, 32'h81);
    @(posedge mclk);
    #1;
    chk1(compOut, 1'b0, "clear");
    model = 1'b0;
    done("latch");
    cfg(7, 1'b0, 1'b0, 1000, 100);
    curHi = 400;
    rd(`ALC_OFF_STAT);
    chk32(rdVal, 32'h04, "clamp status");
    sample(399, 1'b1);
    sample(400, 1'b1);
    wr(`ALC_OFF_CTRL, 32'h1b);
    rd(`ALC_OFF_STAT);
    chk32(rdVal & 32'h11, 32'h11, "invalid selector");
    sample(0, 1'b0);
    wr(`ALC_OFF_MAXTRQ, 32'h28);
    cfg(2, 1'b0, 1'b0, 50, 10);
    rd(`ALC_OFF_STAT);
    chk32(rdVal, 32'h04, "torque limit");
    done("clamp");
    cfg(1, 1'b0, 1'b0, 300, 200);
    route = 13'($urandom_range(13'h1fff));
    wr(`ALC_OFF_ROUTE, {19'h0, route});
    wr(`ALC_OFF_IRQM, 32'h3);
    wr(`ALC_OFF_IRQS, 32'h3);
    sample(500, 1'b1);
    chk32({24'h0, vlinkOut}, {24'h0, route[7:0]}, "links");
    chk32({30'h0, digOut}, {30'h0, route[9:8]}, "digital");
    chk32({29'h0, relayOut}, {29'h0, route[12:10]}, "relay");
    chk1(irq, 1'b1, "irq on rise");
    rd(`ALC_OFF_IRQS);
    chk32(rdVal, 32'h1, "rise event");
    wr(`ALC_OFF_IRQS, 32'h1);
    #1;
    chk1(irq, 1'b0, "irq cleared");
    wr(`ALC_OFF_IRQM, 32'h0);
    sample(0, 1'b1);
    chk1(irq, 1'b0, "irq masked");
    chk32({24'h0, vlinkOut}, 32'h0, "links off");
    rd(`ALC_OFF_IRQS);
    chk32(rdVal, 32'h2, "fall event");
    done("routing");
    results();
  end
endmodule : testbench
